/* design/mlc_deadtime.sv */
// Deadtime generator for one complementary output pair
`timescale 1ns/1ps
module mlc_deadtime (
    input wire logic mclk, // Clock
    input wire logic rst, // Synchronous reset
    input wire logic ce, // Clock enable
    input wire logic restart, // Reinitialise on commutation
    input wire logic base, // Raw modulator waveform
    input wire logic [11:0] dead, // Deadtime in cycles
    output logic hi, // High-side drive
    output logic lo // Low-side drive
);
    typedef struct packed {
        logic last;
        logic [11:0] cnt;
        logic hi;
        logic lo;
    } mlc_dt_t;
    mlc_dt_t r, next_r;

    // Both sides low while the deadtime counter runs after any edge
    always_comb begin
        next_r = r;
        if (restart) begin
            next_r.last = base;
            next_r.cnt = dead;
            next_r.hi = 1'b0;
            next_r.lo = 1'b0;
        end else if (base != r.last) begin
            next_r.last = base;
            next_r.cnt = dead;
            next_r.hi = 1'b0;
            next_r.lo = 1'b0;
        end else if (r.cnt != 12'h000) begin
            next_r.cnt = r.cnt - 12'h001;
        end else begin
            next_r.hi = r.last;
            next_r.lo = ~r.last;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign hi = r.hi;
    assign lo = r.lo;

    never_both_a: assert property (@(posedge mclk) disable iff (rst) !(hi && lo))
        else $error("pair driven high on both sides");
    dead_gap_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && $rose(hi)) |-> $past(!lo))
        else $error("no deadtime before high-side edge");
endmodule

/* design/mlc_pkg.sv */
// Package: register map, field positions, reset values and timing for the motor loop coordinator
package mlc_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CNT_W = 12;
    localparam int NCH = 6;
    localparam int NPAIR = 3;
    // Register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_PERIOD = 4'h1;
    localparam logic [3:0] REG_DEAD = 4'h2;
    localparam logic [3:0] REG_DUTY0 = 4'h3;
    localparam logic [3:0] REG_DUTY1 = 4'h4;
    localparam logic [3:0] REG_DUTY2 = 4'h5;
    localparam logic [3:0] REG_TRIG0 = 4'h6;
    localparam logic [3:0] REG_TRIG1 = 4'h7;
    localparam logic [3:0] REG_DEBUG = 4'h8;
    localparam logic [3:0] REG_STATUS = 4'h9;
    localparam logic [3:0] REG_COUNT = 4'ha;
    // Control field positions
    localparam int CTRL_MOD_EN = 0;
    localparam int CTRL_TDU_EN = 1;
    localparam int CTRL_ADC_EN = 2;
    localparam int CTRL_GATE_EN = 3;
    localparam int CTRL_COMM_EN = 4;
    // Debug field positions
    localparam int DBG_PIN_DIS = 0;
    localparam int DBG_MON_ROUTE = 1;
    localparam int DBG_RELOAD_PE = 2;
    localparam int DBG_TRIG0_PE = 3;
    localparam int DBG_TRIG1_PE = 4;
    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] DEBUG_RST = 16'h0001;
    localparam logic [11:0] PERIOD_RST = 12'h064;
    localparam logic [11:0] DEAD_RST = 12'h002;
    localparam logic [11:0] DUTY_RST = 12'h032;
    localparam logic [11:0] TRIG_RST = 12'h000;
    // Timing: minimum gate-off time after wake before driving again
    localparam int CLK_HZ = 10_000_000;
    localparam int WAKE_SETTLE_NS = 1000;
    localparam int WAKE_SETTLE_CYC = (WAKE_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] WAKE_SETTLE = 4'(WAKE_SETTLE_CYC);
    typedef enum logic [1:0] {MLC_IDLE, MLC_RUN, MLC_STOP, MLC_WAKE} mlc_state_t;
endpackage

/* design/mlc_top.sv */
// Motor loop coordinator: modulator, trigger delay, gate enable and debug routing
// Functional notes
// - Commutation compare event restarts the modulator counter.
// - Trigger delay unit fires ADC triggers at set points each cycle.
// - In stop mode logic halts and gate driver becomes disabled.
// - On wake all module clock enables return together automatically.
// - Transistors are never actively driven during stop mode.
// - Complementary pairing and deadtime hold across stop entry and exit.
// - Pin disable bit set hides commutation signal, cleared drives it.
// - Monitor route sends channels 5-3 to timer port, 2-0 to pwm port.
// - Reload pin enable routes the reload event to its pin.
// - Trigger pin enables route generator 0 or 1 triggers to pins.
// - Center-aligned complementary pairs with deadtime before each edge.
`timescale 1ns/1ps
module mlc_top (
    input wire logic mclk, // 10 MHz bus clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic ce, // Clock enable
    input wire logic [3:0] addr, // Register address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata, // Read data, cycle after rd
    input wire logic stop_req, // Stop mode request
    input wire logic comm_pin, // Commutation compare from general timer
    input wire logic [5:0] gate_fault, // Unused-safe fault inputs, summed
    output logic [5:0] gate_out, // Gate driver outputs to bridge
    output logic gate_active, // Gate driver enabled
    output logic bus_clk_en, // Clock enable to modules
    output logic adc_trig, // ADC trigger pulse
    output logic reload_evt, // Modulator reload pulse
    output logic [2:0] timer_port_low_bits, // Timer port pins 2..0
    output logic [2:0] pwm_port_low_bits, // Pwm port pins 2..0
    output logic comm_pin_out, // Commutation compare pin
    output logic reload_pin, // Reload debug pin
    output logic [1:0] trig_pins // Trigger debug pins
);
    typedef struct packed {
        mlc_pkg::mlc_state_t st;
        logic [15:0] ctrl;
        logic [15:0] debug;
        logic [11:0] period;
        logic [11:0] dead;
        logic [2:0][11:0] duty;
        logic [1:0][11:0] trig;
        logic [11:0] cnt;
        logic dir;
        logic [3:0] settle;
        logic [2:0] comm_sync;
        logic comm_seen;
        logic [2:0] stop_sync;
        logic fault;
        logic [15:0] rdata;
        logic adc_trig;
        logic reload;
        logic [1:0] trig_hit;
        logic gate_active;
        logic [2:0] base;
    } mlc_state_s_t;
    mlc_state_s_t r, next_r;

    logic [5:0] pair_out;
    logic comm_evt;
    logic stop_lvl;
    logic run_en;
    logic restart;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a rise is taken once stages two and three agree
    assign comm_evt = r.comm_sync[1] & r.comm_sync[2] & ~r.comm_seen;
    assign stop_lvl = r.stop_sync[1] & r.stop_sync[2];
    assign run_en = (r.st == mlc_pkg::MLC_RUN) & r.ctrl[mlc_pkg::CTRL_MOD_EN];
    assign restart = comm_evt & r.ctrl[mlc_pkg::CTRL_COMM_EN];

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for registers, modulator, trigger unit and power sequencing
    always_comb begin
        next_r = r;
        next_r.comm_sync = {r.comm_sync[1:0], comm_pin};
        next_r.stop_sync = {r.stop_sync[1:0], stop_req};
        if (r.comm_sync[1] == r.comm_sync[2]) begin
            next_r.comm_seen = r.comm_sync[2];
        end
        next_r.adc_trig = 1'b0;
        next_r.reload = 1'b0;
        next_r.trig_hit = 2'b00;
        // Fault latch: set wins over a software clear in the same cycle
        if (|gate_fault) begin
            next_r.fault = 1'b1;
        end else if (wr && addr == mlc_pkg::REG_STATUS && wdata[0]) begin
            next_r.fault = 1'b0;
        end
        // Register writes
        if (wr) begin
            case (addr)
                mlc_pkg::REG_CTRL: next_r.ctrl = wdata;
                mlc_pkg::REG_PERIOD: next_r.period = wdata[11:0];
                mlc_pkg::REG_DEAD: next_r.dead = wdata[11:0];
                mlc_pkg::REG_DUTY0: next_r.duty[0] = wdata[11:0];
                mlc_pkg::REG_DUTY1: next_r.duty[1] = wdata[11:0];
                mlc_pkg::REG_DUTY2: next_r.duty[2] = wdata[11:0];
                mlc_pkg::REG_TRIG0: next_r.trig[0] = wdata[11:0];
                mlc_pkg::REG_TRIG1: next_r.trig[1] = wdata[11:0];
                mlc_pkg::REG_DEBUG: next_r.debug = wdata;
                default: ;
            endcase
        end
        // Read data stands for one cycle only
        next_r.rdata = 16'h0000;
        if (rd) begin
            case (addr)
                mlc_pkg::REG_CTRL: next_r.rdata = r.ctrl;
                mlc_pkg::REG_PERIOD: next_r.rdata = {4'h0, r.period};
                mlc_pkg::REG_DEAD: next_r.rdata = {4'h0, r.dead};
                mlc_pkg::REG_DUTY0: next_r.rdata = {4'h0, r.duty[0]};
                mlc_pkg::REG_DUTY1: next_r.rdata = {4'h0, r.duty[1]};
                mlc_pkg::REG_DUTY2: next_r.rdata = {4'h0, r.duty[2]};
                mlc_pkg::REG_TRIG0: next_r.rdata = {4'h0, r.trig[0]};
                mlc_pkg::REG_TRIG1: next_r.rdata = {4'h0, r.trig[1]};
                mlc_pkg::REG_DEBUG: next_r.rdata = r.debug;
                mlc_pkg::REG_STATUS: next_r.rdata = {11'h000, r.fault, r.gate_active, 1'b0, r.st};
                mlc_pkg::REG_COUNT: next_r.rdata = {4'h0, r.cnt};
                default: next_r.rdata = 16'h0000;
            endcase
        end
        // Power state sequencing
        case (r.st)
            mlc_pkg::MLC_IDLE: begin
                if (stop_lvl) begin
                    next_r.st = mlc_pkg::MLC_STOP;
                end else if (r.ctrl[mlc_pkg::CTRL_MOD_EN]) begin
                    next_r.st = mlc_pkg::MLC_RUN;
                end
            end
            mlc_pkg::MLC_RUN: begin
                if (stop_lvl) begin
                    next_r.st = mlc_pkg::MLC_STOP;
                end else if (!r.ctrl[mlc_pkg::CTRL_MOD_EN]) begin
                    next_r.st = mlc_pkg::MLC_IDLE;
                end
            end
            mlc_pkg::MLC_STOP: begin
                // Gate enable dropped so the bridge never sees a frozen drive
                next_r.ctrl[mlc_pkg::CTRL_GATE_EN] = 1'b0;
                if (!stop_lvl) begin
                    next_r.st = mlc_pkg::MLC_WAKE;
                    next_r.settle = mlc_pkg::WAKE_SETTLE;
                end
            end
            mlc_pkg::MLC_WAKE: begin
                if (r.settle != 4'h0) begin
                    next_r.settle = r.settle - 4'h1;
                end else begin
                    next_r.st = mlc_pkg::MLC_IDLE;
                end
            end
            default: next_r.st = mlc_pkg::MLC_IDLE;
        endcase
        // Center-aligned up/down counter, restarted on commutation
        if (restart) begin
            next_r.cnt = 12'h000;
            next_r.dir = 1'b0;
            next_r.reload = 1'b1;
        end else if (run_en) begin
            if (!r.dir) begin
                if (r.cnt >= r.period - 12'h001) begin
                    next_r.dir = 1'b1;
                end
                next_r.cnt = r.cnt + 12'h001;
            end else begin
                if (r.cnt <= 12'h001) begin
                    next_r.dir = 1'b0;
                    next_r.reload = 1'b1;
                end
                next_r.cnt = r.cnt - 12'h001;
            end
        end
        // Base waveforms: high while counter below duty, symmetric about center
        for (int i = 0; i < mlc_pkg::NPAIR; i++) begin
            next_r.base[i] = run_en & (r.cnt < r.duty[i]);
        end
        // Trigger delay unit: compare on the up-count, one pulse each
        if (run_en && r.ctrl[mlc_pkg::CTRL_TDU_EN] && !r.dir) begin
            for (int g = 0; g < 2; g++) begin
                if (r.cnt == r.trig[g]) begin
                    next_r.trig_hit[g] = 1'b1;
                end
            end
        end
        next_r.adc_trig = (|next_r.trig_hit) & r.ctrl[mlc_pkg::CTRL_ADC_EN];
        // Gate driver active only while running, enabled and fault free
        next_r.gate_active = run_en & r.ctrl[mlc_pkg::CTRL_GATE_EN] & ~r.fault & ~stop_lvl;
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk) begin
        if (rst) begin
            r <= '0;
            r.st <= mlc_pkg::MLC_IDLE;
            r.ctrl <= mlc_pkg::CTRL_RST;
            r.debug <= mlc_pkg::DEBUG_RST;
            r.period <= mlc_pkg::PERIOD_RST;
            r.dead <= mlc_pkg::DEAD_RST;
            r.duty <= {3{mlc_pkg::DUTY_RST}};
            r.trig <= {2{mlc_pkg::TRIG_RST}};
        end else if (ce) begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One deadtime pair per channel pair
    genvar p;
    generate
        for (p = 0; p < mlc_pkg::NPAIR; p++) begin : g_pair
            mlc_deadtime u_dt (
                .mclk(mclk),
                .rst(rst),
                .ce(ce),
                .restart(restart),
                .base(r.base[p]),
                .dead(r.dead),
                .hi(pair_out[2 * p]),
                .lo(pair_out[2 * p + 1])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Outputs and debug routing
    assign bus_clk_en = (r.st != mlc_pkg::MLC_STOP);
    assign gate_active = r.gate_active;
    // Disabled gate forces both sides low, preserving pair exclusivity
    assign gate_out = r.gate_active ? pair_out : 6'h00;
    assign adc_trig = r.adc_trig;
    assign reload_evt = r.reload;
    assign rdata = r.rdata;
    assign comm_pin_out = ~r.debug[mlc_pkg::DBG_PIN_DIS] & r.comm_sync[2];
    assign timer_port_low_bits = r.debug[mlc_pkg::DBG_MON_ROUTE] ? pair_out[5:3] : 3'h0;
    assign pwm_port_low_bits = r.debug[mlc_pkg::DBG_MON_ROUTE] ? pair_out[2:0] : 3'h0;
    assign reload_pin = r.debug[mlc_pkg::DBG_RELOAD_PE] & r.reload;
    assign trig_pins[0] = r.debug[mlc_pkg::DBG_TRIG0_PE] & r.trig_hit[0];
    assign trig_pins[1] = r.debug[mlc_pkg::DBG_TRIG1_PE] & r.trig_hit[1];

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    restart_cnt_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && restart) |=> (r.cnt == 12'h000))
        else $error("commutation did not restart counter");
    stop_gate_a: assert property (@(posedge mclk) disable iff (rst)
        (r.st == mlc_pkg::MLC_STOP) |-> (gate_out == 6'h00))
        else $error("gates driven in stop");
    stop_gate_off_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && stop_lvl) |=> !gate_active)
        else $error("gate still active after stop");
    pin_hide_a: assert property (@(posedge mclk) disable iff (rst)
        r.debug[mlc_pkg::DBG_PIN_DIS] |-> !comm_pin_out)
        else $error("commutation visible with pin disabled");
    mon_route_a: assert property (@(posedge mclk) disable iff (rst)
        r.debug[mlc_pkg::DBG_MON_ROUTE] |-> ({timer_port_low_bits, pwm_port_low_bits} == pair_out))
        else $error("monitor route mismatch");
    reload_pin_a: assert property (@(posedge mclk) disable iff (rst)
        (r.debug[mlc_pkg::DBG_RELOAD_PE] && reload_evt) |-> reload_pin)
        else $error("reload not on pin");
    trig_pin_a: assert property (@(posedge mclk) disable iff (rst)
        (trig_pins[0] |-> r.debug[mlc_pkg::DBG_TRIG0_PE]) and (trig_pins[1] |-> r.debug[mlc_pkg::DBG_TRIG1_PE]))
        else $error("trigger pin without enable");
    trig_adc_a: assert property (@(posedge mclk) disable iff (rst)
        (adc_trig |-> (|r.trig_hit)))
        else $error("adc trigger without match");
    wake_clk_a: assert property (@(posedge mclk) disable iff (rst)
        (ce && r.st == mlc_pkg::MLC_STOP && !stop_lvl) |=> bus_clk_en)
        else $error("clocks not restored on wake");
    debug_rst_a: assert property (@(posedge mclk)
        $past(rst) |-> (r.debug[4:1] == 4'h0))
        else $error("debug routing not cleared by reset");
    stop_c: cover property (@(posedge mclk) disable iff (rst) r.st == mlc_pkg::MLC_STOP ##1 r.st == mlc_pkg::MLC_WAKE);
    restart_c: cover property (@(posedge mclk) disable iff (rst) restart);
    trig_c: cover property (@(posedge mclk) disable iff (rst) adc_trig);
    gate_c: cover property (@(posedge mclk) disable iff (rst) gate_active && (|gate_out));
endmodule

/* test/mlc_bridge_model.sv */
// Power bridge model: watches gate drives and raises a fault on command
`timescale 1ns/1ps
module mlc_bridge_model (
    input wire logic mclk, // Bus clock
    input wire logic [5:0] gate_out, // Gate drives from the block
    input wire logic bus_clk_en, // Low while the device is stopped
    input wire logic [11:0] dead, // Programmed dead time in cycles
    input wire logic fault_cmd, // Bench asks for a bridge fault
    input wire logic [3:0] fault_dly, // Fault answer delay, 0 is prompt
    output logic [5:0] gate_fault, // Fault lines back to the block
    output int viol // Count of unsafe drive patterns seen
);
    int low_run [6];
    logic [5:0] prev = 6'h00;
    logic [15:0] fault_sr = 16'h0000;
    initial viol = 0;
    initial for (int i = 0; i < 6; i++) low_run[i] = 0;
    // Fault answered after a chosen delay, other lines held low
    assign gate_fault = {5'h00, fault_sr[fault_dly]};
    //////////////////////////////////////////////////////////////////////////////
    // Shoot-through, dead time and drive during stop all count as damage
    always @(posedge mclk) begin
        fault_sr <= {fault_sr[14:0], fault_cmd};
        for (int p = 0; p < 3; p++) begin
            if (gate_out[2*p] === 1'b1 && gate_out[2*p+1] === 1'b1) viol++;
            for (int s = 0; s < 2; s++) begin
                if (gate_out[2*p+s] === 1'b1 && prev[2*p+s] === 1'b0 && low_run[2*p+1-s] < int'(dead)) viol++;
            end
        end
        if (bus_clk_en === 1'b0 && gate_out !== 6'h00) viol++;
        for (int i = 0; i < 6; i++) low_run[i] = (gate_out[i] === 1'b0) ? low_run[i] + 1 : 0;
        prev <= gate_out;
    end
endmodule

/* test/tb_motor_loop_coordination.sv */
// Self-checking bench for the motor loop coordinator
`timescale 1ns/1ps
module tb_motor_loop_coordination;
    logic mclk, rst, ce, wr, rd, stop_req, comm_pin, fault_cmd, rd_d1;
    logic [3:0] addr;
    logic [15:0] wdata, rdata;
    logic [5:0] gate_fault, gate_out;
    logic gate_active, bus_clk_en, adc_trig, reload_evt, comm_pin_out, reload_pin;
    logic [2:0] timer_port_low_bits, pwm_port_low_bits;
    logic [1:0] trig_pins;
    logic [15:0] exp_q [$];
    int n_mismatch = 0, compares = 0, viol, t0, t1, na, nb, hit, d, per;
    mlc_top i_dut (.mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .stop_req(stop_req), .comm_pin(comm_pin), .gate_fault(gate_fault), .gate_out(gate_out),
        .gate_active(gate_active), .bus_clk_en(bus_clk_en), .adc_trig(adc_trig), .reload_evt(reload_evt),
        .timer_port_low_bits(timer_port_low_bits), .pwm_port_low_bits(pwm_port_low_bits),
        .comm_pin_out(comm_pin_out), .reload_pin(reload_pin), .trig_pins(trig_pins));
    mlc_bridge_model i_bridge (.mclk(mclk), .gate_out(gate_out), .bus_clk_en(bus_clk_en), .dead(12'h003),
        .fault_cmd(fault_cmd), .fault_dly(4'h3), .gate_fault(gate_fault), .viol(viol));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    //////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Bus cycles start on a fresh edge so a strobe is never assigned twice at once
    task wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(v);
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task cycles(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Counts pin activity over one full modulator cycle, reload to reload
    task measure();
        int seen;
        seen = 0; t0 = 0; t1 = 0; na = 0; nb = 0; per = 0;
        for (int k = 0; k < 200 && seen < 2; k++) begin
            cycles(1);
            if (reload_evt === 1'b1) seen++;
            if (seen == 1) begin
                per++;
                t0 += (trig_pins[0] === 1'b1);
                t1 += (trig_pins[1] === 1'b1);
                na += (adc_trig === 1'b1);
            end
            if (reload_pin !== reload_evt || {timer_port_low_bits, pwm_port_low_bits} !== gate_out) nb++;
        end
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // Read data stands only in the cycle after the strobe, so compare exactly there
    always @(posedge mclk) begin
        if (rd_d1 === 1'b1 && exp_q.size() > 0) chk(rdata, exp_q.pop_front());
        rd_d1 <= rd & ce;
    end
    // Cut a hang short well past the expected run length
    initial begin
        #(100 * 20000);
        n_mismatch++;
        final_report();
    end
    initial begin
        rst = 1'b1; ce = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0; wdata = 16'h0000; rd_d1 = 1'b0;
        stop_req = 1'b0; comm_pin = 1'b0; fault_cmd = 1'b0;
        void'($urandom(2878));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        // Reset values, unmapped place and quiet debug pins
        rd_reg(mlc_pkg::REG_DEBUG, 16'h0001);
        rd_reg(mlc_pkg::REG_CTRL, 16'h0000);
        rd_reg(4'hf, 16'h0000);
        wr_reg(4'hf, 16'h1234);
        rd_reg(4'hf, 16'h0000);
        cycles(2);
        chk({11'h000, trig_pins, reload_pin, comm_pin_out, bus_clk_en}, 16'h0001);
        $display("test reset done");
        // Start-up in the recommended order, gate driver last, duties split around half
        d = 1 + ($urandom % 8);
        wr_reg(mlc_pkg::REG_PERIOD, 16'h0014);
        wr_reg(mlc_pkg::REG_DEAD, 16'h0003);
        wr_reg(mlc_pkg::REG_DUTY0, 16'(10 + d));
        wr_reg(mlc_pkg::REG_DUTY1, 16'(10 - d));
        wr_reg(mlc_pkg::REG_DUTY2, 16'h000a);
        wr_reg(mlc_pkg::REG_TRIG0, 16'h0005);
        wr_reg(mlc_pkg::REG_TRIG1, 16'h000c);
        wr_reg(mlc_pkg::REG_CTRL, 16'h0017);
        cycles(5);
        chk({15'h0000, gate_active}, 16'h0000);
        wr_reg(mlc_pkg::REG_CTRL, 16'h001f);
        wr_reg(mlc_pkg::REG_DEBUG, 16'h001e);
        cycles(3);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0009);
        $display("test startup done");
        // One trigger per generator and per cycle, pins mirror internal events
        measure();
        chk(16'(t0), 16'h0001);
        chk(16'(t1), 16'h0001);
        chk(16'(na), 16'h0002);
        chk(16'(nb), 16'h0000);
        chk(16'(per), 16'h0028);
        $display("test routing done");
        // Commutation restarts the counter mid-cycle, pin shows it only when allowed
        for (int pass = 0; pass < 2; pass++) begin
            hit = 0;
            measure();
            cycles(6);
            @(posedge mclk) comm_pin <= 1'b1;
            for (int k = 0; k < 8; k++) begin
                cycles(1);
                if (reload_evt === 1'b1) hit = 1;
            end
            chk(16'(hit), 16'h0001);
            chk({15'h0000, comm_pin_out}, {15'h0000, pass == 0});
            @(posedge mclk) comm_pin <= 1'b0;
            wr_reg(mlc_pkg::REG_DEBUG, 16'h001f);
        end
        $display("test commutation done");
        // Shutdown: zero mean bridge voltage first, then gates safe, verified before stop
        wr_reg(mlc_pkg::REG_DUTY0, 16'h000a);
        wr_reg(mlc_pkg::REG_DUTY1, 16'h000a);
        cycles(40);
        wr_reg(mlc_pkg::REG_CTRL, 16'h0017);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0001);
        // Stop entry and wake: gates off, clocks back alone
        @(posedge mclk) stop_req <= 1'b1;
        for (int k = 0; k < 10 && bus_clk_en !== 1'b0; k++) cycles(1);
        cycles(1);
        chk({gate_active, bus_clk_en, 8'h00, gate_out}, 16'h0000);
        cycles(20);
        @(posedge mclk) stop_req <= 1'b0;
        hit = 0;
        for (int k = 0; k < 10; k++) begin
            cycles(1);
            if (bus_clk_en === 1'b1) hit = 1;
        end
        chk(16'(hit), 16'h0001);
        cycles(30);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0001);
        rd_reg(mlc_pkg::REG_CTRL, 16'h0017);
        // Duties recomputed while outputs are still safe, gates enabled only afterwards
        wr_reg(mlc_pkg::REG_DUTY0, 16'(10 + d));
        wr_reg(mlc_pkg::REG_DUTY1, 16'(10 - d));
        wr_reg(mlc_pkg::REG_CTRL, 16'h001f);
        cycles(3);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0009);
        $display("test stop done");
        // Bridge fault takes the gates away until software clears it
        @(posedge mclk) fault_cmd <= 1'b1;
        cycles(8);
        chk({15'h0000, gate_active}, 16'h0000);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0011);
        @(posedge mclk) fault_cmd <= 1'b0;
        cycles(8);
        wr_reg(mlc_pkg::REG_STATUS, 16'h0001);
        cycles(3);
        rd_reg(mlc_pkg::REG_STATUS, 16'h0009);
        cycles(60);
        chk(16'(viol), 16'h0000);
        $display("test fault done");
        cycles(3);
        final_report();
    end
endmodule
